// ---- core/can_mode_pkg.sv ----
// Shared types and constants for CAN mode control and transmit mailboxes.
// Assumes one controller clock domain and a bit-timing unit elsewhere.
package can_mode_pkg;
    typedef enum logic [1:0] {
        MODE_SLEEP = 2'b00,
        MODE_INIT = 2'b01,
        MODE_SYNC = 2'b10,
        MODE_NORMAL = 2'b11
    } mode_t;
    typedef enum logic [1:0] {
        MB_EMPTY = 2'b00,
        MB_PENDING = 2'b01,
        MB_SCHEDULED = 2'b10,
        MB_TRANSMIT = 2'b11
    } mb_state_t;
    localparam int ID_W = 29;
    localparam int NUM_MAILBOXES = 2;
    localparam logic [ID_W-1:0] ID_RESET = 29'h0000000;
    localparam logic [3:0] SYNC_RECESSIVE_BITS = 4'hb;
    localparam logic [3:0] SYNC_CNT_RESET = 4'h0;
    localparam logic RECESSIVE = 1'b1;
    localparam logic INIT_ACKNOWLEDGE_RESET = 1'b0;
    localparam logic SLEEP_ACKNOWLEDGE_RESET = 1'b1;
endpackage

// ---- core/can_tx_mailbox.sv ----
// One transmit mailbox: identifier store, state and completion flags.
// Assumes scheduler and protocol core strobes are on the same clock.
`timescale 1ns/1ns
`default_nettype none
module can_tx_mailbox
    import can_mode_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Software side
    input wire logic i_hold,
    input wire logic i_wr_en,
    input wire logic [ID_W-1:0] i_wr_id,
    input wire logic i_tx_req,
    input wire logic i_abort,
    input wire logic i_flag_clr,
    input wire logic i_no_auto_retransmit,
    // Scheduler and core
    input wire logic i_win,
    input wire logic i_start,
    input wire logic i_done,
    input wire logic i_arb_lost,
    input wire logic i_error,
    // State and flags
    output var mb_state_t o_state,
    output logic [ID_W-1:0] o_id,
    output logic o_request_complete,
    output logic o_transmit_ok,
    output logic o_arbitration_lost,
    output logic o_transmit_error
);
    logic abort_pend;
    logic in_tx;
    logic ev_done;
    logic ev_fail;
    logic ev_abort;
    logic ev_end;

    assign in_tx = (o_state == MB_TRANSMIT) && !i_hold;
    assign ev_done = in_tx && i_done;
    assign ev_fail = in_tx && !i_done && (i_arb_lost || i_error);
    assign ev_abort = !i_hold && i_abort &&
        (o_state == MB_PENDING || o_state == MB_SCHEDULED);
    assign ev_end = ev_fail && (i_no_auto_retransmit || abort_pend || i_abort);

    // Writes land only while empty
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_id <= ID_RESET;
        end else if (i_wr_en && o_state == MB_EMPTY) begin
            o_id <= i_wr_id;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_state <= MB_EMPTY;
        end else if (!i_hold) begin
            case (o_state)
                MB_EMPTY: begin
                    if (i_tx_req) begin
                        o_state <= MB_PENDING;
                    end
                end
                MB_PENDING: begin
                    if (i_abort) begin
                        o_state <= MB_EMPTY;
                    end else if (i_win) begin
                        o_state <= MB_SCHEDULED;
                    end
                end
                MB_SCHEDULED: begin
                    if (i_abort) begin
                        o_state <= MB_EMPTY;
                    end else if (i_start) begin
                        o_state <= MB_TRANSMIT;
                    end else if (!i_win) begin
                        o_state <= MB_PENDING;
                    end
                end
                MB_TRANSMIT: begin
                    if (ev_done || ev_end) begin
                        o_state <= MB_EMPTY;
                    end else if (ev_fail) begin
                        o_state <= MB_PENDING;
                    end
                end
                default: begin
                    o_state <= MB_EMPTY;
                end
            endcase
        end
    end

    // Abort during transmit waits for the attempt to end
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            abort_pend <= 1'b0;
        end else if (o_state != MB_TRANSMIT) begin
            abort_pend <= 1'b0;
        end else if (in_tx && i_abort) begin
            abort_pend <= 1'b1;
        end
    end

    // Set beats a same-cycle software clear
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_request_complete <= 1'b0;
            o_transmit_ok <= 1'b0;
            o_arbitration_lost <= 1'b0;
            o_transmit_error <= 1'b0;
        end else begin
            if (ev_done || ev_abort || ev_end) begin
                o_request_complete <= 1'b1;
            end else if (i_flag_clr) begin
                o_request_complete <= 1'b0;
            end
            if (ev_done) begin
                o_transmit_ok <= 1'b1;
            end else if (ev_abort || ev_end || i_flag_clr) begin
                o_transmit_ok <= 1'b0;
            end
            if (ev_fail && i_arb_lost) begin
                o_arbitration_lost <= 1'b1;
            end else if (i_flag_clr) begin
                o_arbitration_lost <= 1'b0;
            end
            if (ev_fail && i_error) begin
                o_transmit_error <= 1'b1;
            end else if (i_flag_clr) begin
                o_transmit_error <= 1'b0;
            end
        end
    end

    chk_write_block: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (o_state != MB_EMPTY) |=> $stable(o_id))
        else $error("mailbox id changed while not empty");

    chk_abort_empty: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        ev_abort |=> (o_state == MB_EMPTY) && o_request_complete && !o_transmit_ok)
        else $error("abort did not empty the mailbox");

    chk_no_auto_retransmit_once: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (ev_fail && i_no_auto_retransmit) |=> (o_state == MB_EMPTY) && o_request_complete && !o_transmit_ok)
        else $error("single-shot attempt was retried");
endmodule
`default_nettype wire

// ---- core/can_mode_tx_ctrl.sv ----
// CAN operating mode control, test mode pin routing and transmit scheduling.
// Assumes bit tick, bus idle and tx outcome strobes come from the protocol
// core on I_CLK; the receive pin is asynchronous.
// Function
// - Reset lands the controller in sleep
// - Request bits answered by matching acknowledge bits
// - Eleven recessive bits before joining the bus
// - Initialization halts transfers, transmit pin recessive
// - Mode changes never alter configuration
// - Sleep freezes mailbox state and flags; software flag clears still act
// - Initialization request ignored while asleep
// - Bus activity or software ends sleep
// - Wake-up interrupt on bus activity when enabled
// - Sleep acknowledge drops on leaving synchronization, for normal mode or initialization
// - Test options latched only during initialization
// - Silent: recessive pin, dominant bits looped internally
// - Loop back feeds transmit into receive
// - Combined mode isolates both pins
// - Mailbox writes blocked once not empty
// - Pending, scheduled, transmit, then empty with flags
// - Failure reports arbitration lost or error
// - Lowest identifier first, ties to mailbox zero
// - FIFO priority follows request order
// - Abort empties mailbox by transmission end
// - Single-shot mode attempts each message once
// - Exactly two transmit mailboxes
`timescale 1ns/1ns
`default_nettype none
module can_mode_tx_ctrl
    import can_mode_pkg::*;
(
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_B,
    // Mode control
    input wire logic I_INIT_REQUEST,
    input wire logic I_SLEEP_REQUEST,
    input wire logic I_AUTO_WAKEUP_ENABLE,
    input wire logic I_WAKEUP_IRQ_ENABLE,
    input wire logic I_SILENT_SELECT,
    input wire logic I_LOOPBACK_SELECT,
    input wire logic I_TX_FIFO_PRIORITY,
    input wire logic I_NO_AUTO_RETRANSMIT,
    // Mode status
    output logic O_INIT_ACKNOWLEDGE,
    output logic O_SLEEP_ACKNOWLEDGE,
    output logic O_SLEEP_REQUEST_CLR,
    output logic O_WAKEUP_IRQ,
    output logic O_IGNORE_ACK_ERR,
    // Mailbox software access
    input wire logic I_MB_WR_EN,
    input wire logic I_MB_SEL,
    input wire logic [ID_W-1:0] I_MB_ID,
    input wire logic [1:0] I_TRANSMIT_REQUEST,
    input wire logic [1:0] I_ABORT_REQUEST,
    input wire logic [1:0] I_FLAG_CLEAR,
    // Mailbox status
    output logic [3:0] O_MB_STATE,
    output logic [1:0] O_REQUEST_COMPLETE,
    output logic [1:0] O_TRANSMIT_OK,
    output logic [1:0] O_ARBITRATION_LOST,
    output logic [1:0] O_TRANSMIT_ERROR,
    // Protocol core
    input wire logic I_BIT_TICK,
    input wire logic I_BUS_IDLE,
    input wire logic I_CORE_TX_BIT,
    input wire logic I_TX_DONE,
    input wire logic I_TX_ARB_LOST,
    input wire logic I_TX_ERROR,
    output logic O_CORE_RX_BIT,
    output logic O_TX_START,
    output logic O_TX_MB,
    output logic [ID_W-1:0] O_TX_ID,
    // Bus pins
    input wire logic I_BUS_RECEIVE_PIN,
    output logic O_BUS_TRANSMIT_PIN
);
    mode_t mode;
    mode_t next_mode;
    logic rx_meta;
    logic rx_sync;
    logic rx_prev;
    logic [3:0] rec_cnt;
    logic wake_pend;
    logic wake_ev;
    logic eff_sleep;
    logic test_silent;
    logic test_loop;
    logic core_tx;
    logic core_rx;
    logic hold;
    logic tx_busy;
    logic first_mb;
    logic [1:0] cand;
    logic [1:0] win;
    logic pick1;
    logic can_start;
    mb_state_t st [NUM_MAILBOXES];
    logic [ID_W-1:0] mid [NUM_MAILBOXES];

    // Pin passes two flops before use
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            rx_meta <= RECESSIVE;
            rx_sync <= RECESSIVE;
            rx_prev <= RECESSIVE;
        end else begin
            rx_meta <= I_BUS_RECEIVE_PIN;
            rx_sync <= rx_meta;
            rx_prev <= rx_sync;
        end
    end

    // Test options only move in initialization
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            test_silent <= 1'b0;
            test_loop <= 1'b0;
        end else if (mode == MODE_INIT) begin
            test_silent <= I_SILENT_SELECT;
            test_loop <= I_LOOPBACK_SELECT;
        end
    end

    // Core transmit forced recessive outside normal mode
    assign core_tx = (mode == MODE_NORMAL) ? I_CORE_TX_BIT : RECESSIVE;

    always_comb begin
        if (test_loop) begin
            core_rx = core_tx;
        end else if (test_silent) begin
            core_rx = rx_sync & core_tx;
        end else begin
            core_rx = rx_sync;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_BUS_TRANSMIT_PIN <= RECESSIVE;
            O_CORE_RX_BIT <= RECESSIVE;
            O_IGNORE_ACK_ERR <= 1'b0;
        end else begin
            O_BUS_TRANSMIT_PIN <= test_silent ? RECESSIVE : core_tx;
            O_CORE_RX_BIT <= core_rx;
            O_IGNORE_ACK_ERR <= test_loop;
        end
    end

    // Bus idle detector; counts only while synchronizing
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            rec_cnt <= SYNC_CNT_RESET;
        end else if (mode != MODE_SYNC) begin
            rec_cnt <= SYNC_CNT_RESET;
        end else if (I_BIT_TICK) begin
            if (!core_rx) begin
                rec_cnt <= SYNC_CNT_RESET;
            end else if (rec_cnt != SYNC_RECESSIVE_BITS) begin
                rec_cnt <= rec_cnt + 4'h1;
            end
        end
    end

    // Wake only on a dominant edge at the pin, in loop back as well
    assign wake_ev = (mode == MODE_SLEEP) && rx_prev && !rx_sync;
    assign eff_sleep = I_SLEEP_REQUEST && !wake_pend;

    // Covers the gap until software drops its sleep bit
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            wake_pend <= 1'b0;
        end else if (wake_ev && I_AUTO_WAKEUP_ENABLE) begin
            wake_pend <= 1'b1;
        end else if (!I_SLEEP_REQUEST) begin
            wake_pend <= 1'b0;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_SLEEP_REQUEST_CLR <= 1'b0;
            O_WAKEUP_IRQ <= 1'b0;
        end else begin
            O_SLEEP_REQUEST_CLR <= wake_ev && I_AUTO_WAKEUP_ENABLE;
            O_WAKEUP_IRQ <= wake_ev && I_WAKEUP_IRQ_ENABLE;
        end
    end

    // Mode sequencing; no configuration is touched here
    always_comb begin
        next_mode = mode;
        case (mode)
            MODE_SLEEP: begin
                if (!eff_sleep) begin
                    next_mode = MODE_SYNC;
                end
            end
            MODE_SYNC: begin
                if (eff_sleep) begin
                    next_mode = MODE_SLEEP;
                end else if (I_INIT_REQUEST) begin
                    next_mode = MODE_INIT;
                end else if (rec_cnt == SYNC_RECESSIVE_BITS) begin
                    next_mode = MODE_NORMAL;
                end
            end
            MODE_INIT: begin
                if (eff_sleep) begin
                    next_mode = MODE_SLEEP;
                end else if (!I_INIT_REQUEST) begin
                    next_mode = MODE_SYNC;
                end
            end
            MODE_NORMAL: begin
                // Let a frame in flight finish before leaving the bus
                if (!tx_busy && I_INIT_REQUEST) begin
                    next_mode = MODE_INIT;
                end else if (!tx_busy && eff_sleep) begin
                    next_mode = MODE_SLEEP;
                end
            end
            default: begin
                next_mode = MODE_SLEEP;
            end
        endcase
    end

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            mode <= MODE_SLEEP;
        end else begin
            mode <= next_mode;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_INIT_ACKNOWLEDGE <= INIT_ACKNOWLEDGE_RESET;
            O_SLEEP_ACKNOWLEDGE <= SLEEP_ACKNOWLEDGE_RESET;
        end else begin
            O_INIT_ACKNOWLEDGE <= (next_mode == MODE_INIT);
            if (next_mode == MODE_SLEEP) begin
                O_SLEEP_ACKNOWLEDGE <= 1'b1;
            end else if (next_mode != MODE_SYNC) begin
                O_SLEEP_ACKNOWLEDGE <= 1'b0;
            end
        end
    end

    // Scheduler
    assign hold = (mode == MODE_SLEEP);
    assign tx_busy = (st[0] == MB_TRANSMIT) || (st[1] == MB_TRANSMIT);
    assign cand[0] = (st[0] == MB_PENDING) || (st[0] == MB_SCHEDULED);
    assign cand[1] = (st[1] == MB_PENDING) || (st[1] == MB_SCHEDULED);
    assign pick1 = cand[1] && (!cand[0] ||
        (I_TX_FIFO_PRIORITY ? first_mb : (mid[1] < mid[0])));
    assign win[1] = pick1;
    assign win[0] = cand[0] && !pick1;
    assign can_start = (mode == MODE_NORMAL) && !test_silent && I_BUS_IDLE &&
        !tx_busy && ((win[0] && st[0] == MB_SCHEDULED) ||
        (win[1] && st[1] == MB_SCHEDULED));

    // Oldest request; one step behind the request itself
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            first_mb <= 1'b0;
        end else if (cand[1] && !cand[0]) begin
            first_mb <= 1'b1;
        end else if (!cand[1]) begin
            first_mb <= 1'b0;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_TX_START <= 1'b0;
            O_TX_MB <= 1'b0;
            O_TX_ID <= ID_RESET;
        end else begin
            O_TX_START <= can_start;
            if (can_start) begin
                O_TX_MB <= pick1;
                O_TX_ID <= pick1 ? mid[1] : mid[0];
            end
        end
    end

    generate
        for (genvar g = 0; g < NUM_MAILBOXES; g++) begin : gen_mb
            can_tx_mailbox u_mb (
                .i_clk(I_CLK),
                .i_rst_b(I_RST_B),
                .i_hold(hold),
                .i_wr_en(I_MB_WR_EN && (I_MB_SEL == 1'(g))),
                .i_wr_id(I_MB_ID),
                .i_tx_req(I_TRANSMIT_REQUEST[g]),
                .i_abort(I_ABORT_REQUEST[g]),
                .i_flag_clr(I_FLAG_CLEAR[g]),
                .i_no_auto_retransmit(I_NO_AUTO_RETRANSMIT),
                .i_win(win[g]),
                .i_start(can_start && win[g]),
                .i_done(I_TX_DONE),
                .i_arb_lost(I_TX_ARB_LOST),
                .i_error(I_TX_ERROR),
                .o_state(st[g]),
                .o_id(mid[g]),
                .o_request_complete(O_REQUEST_COMPLETE[g]),
                .o_transmit_ok(O_TRANSMIT_OK[g]),
                .o_arbitration_lost(O_ARBITRATION_LOST[g]),
                .o_transmit_error(O_TRANSMIT_ERROR[g])
            );
        end
    endgenerate

    assign O_MB_STATE = {st[1], st[0]};

    chk_sleep_no_init: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        (mode == MODE_SLEEP && eff_sleep) |=> !O_INIT_ACKNOWLEDGE && O_SLEEP_ACKNOWLEDGE)
        else $error("init acknowledged while asleep");

    chk_sync_bits: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        (mode == MODE_SYNC && next_mode == MODE_NORMAL) |-> rec_cnt == SYNC_RECESSIVE_BITS)
        else $error("normal mode entered before bus idle");

    chk_init_quiet: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        (mode == MODE_INIT) |=> O_BUS_TRANSMIT_PIN && !O_TX_START)
        else $error("bus activity during initialization");

    chk_silent_pin: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        test_silent |=> O_BUS_TRANSMIT_PIN && !O_TX_START)
        else $error("silent mode drove the bus");

    chk_loop_feed: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        test_loop |=> O_CORE_RX_BIT == $past(core_tx))
        else $error("loop back not fed from transmit");

    chk_wake_pulses: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        (wake_ev && I_WAKEUP_IRQ_ENABLE) |=> O_WAKEUP_IRQ ##1 !O_WAKEUP_IRQ)
        else $error("wake-up interrupt missing");

    chk_sleep_acknowledge_sync: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        $fell(O_SLEEP_ACKNOWLEDGE) |-> $past(mode) == MODE_SYNC)
        else $error("sleep acknowledge dropped before sync");

    chk_prio_id: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        (can_start && &cand && !I_TX_FIFO_PRIORITY && mid[0] <= mid[1])
        |=> st[0] == MB_TRANSMIT && !O_TX_MB)
        else $error("higher identifier sent first");

    chk_fifo_order: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        (can_start && &cand && I_TX_FIFO_PRIORITY) |=> O_TX_MB == $past(first_mb))
        else $error("request order not kept");

    chk_sleep_freeze: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        (hold && !(|I_FLAG_CLEAR)) |=> $stable(O_REQUEST_COMPLETE) && $stable(O_MB_STATE))
        else $error("status moved in sleep");
endmodule
`default_nettype wire

// ---- sim/can_bus_model.sv ----
// Stand-in for the CAN bus and protocol core timing: bit ticks, idle, receive pin.
// Assumes one clock; the bench pulses i_wake for bus activity, i_busy to stall.
`timescale 1ns/1ns
`default_nettype none
module can_bus_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Control
    input wire logic i_wake,
    input wire logic i_busy,
    // Bus side
    output logic o_rx,
    output logic o_tick,
    output logic o_idle
);
    logic [1:0] div;
    logic [2:0] dom;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            div <= 2'h0;
            dom <= 3'h0;
        end else begin
            div <= div + 2'h1;
            dom <= i_wake ? 3'h6 : (dom != 3'h0 ? dom - 3'h1 : 3'h0);
        end
    end
    // Pull-up: recessive whenever no node drives dominant
    assign o_rx = (dom == 3'h0);
    assign o_tick = (div == 2'h3);
    assign o_idle = o_rx & !i_busy;
endmodule
`default_nettype wire

// ---- sim/can_mode_and_tx_control_bench.sv ----
// Self-checking bench for mode control and transmit mailboxes.
// Assumes the bus model stands in for bus and core timing.
`timescale 1ns/1ns
`default_nettype none
module can_mode_and_tx_control_bench;
    import can_mode_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, init_rq = 1'b0, sleep_rq = 1'b1, fifo = 1'b0;
    logic no_auto_retransmit = 1'b0, wr = 1'b0, sel = 1'b0, wake = 1'b0, busy = 1'b0;
    logic sil = 1'b0, lbk = 1'b0, ctx = 1'b1, init_acknowledge, sleep_acknowledge, slclr, wirq, start, mb;
    logic txpin, rx, tick, idle, rxc, iack;
    logic [ID_W-1:0] id = ID_RESET, tx_id;
    logic [1:0] request_complete, transmit_ok, arbitration_lost, transmit_error;
    // Strobes as {flag clear, abort, request}; outcomes as {error, lost, done}
    logic [5:0] strb = 6'h0;
    logic [2:0] ends = 3'h0;
    logic [3:0] st, seen;
    int fail_count = 0, checked = 0, cycles = 0, n;
    assign seen = {start, init_acknowledge, sleep_acknowledge, wirq};
    always #25 clk = ~clk;
    can_bus_model bus (.i_clk(clk), .i_rst_b(rst_b), .i_wake(wake), .i_busy(busy),
        .o_rx(rx), .o_tick(tick), .o_idle(idle));
    can_mode_tx_ctrl uut (.I_CLK(clk), .I_RST_B(rst_b), .I_INIT_REQUEST(init_rq),
        .I_SLEEP_REQUEST(sleep_rq), .I_AUTO_WAKEUP_ENABLE(1'b1),
        .I_WAKEUP_IRQ_ENABLE(1'b1), .I_SILENT_SELECT(sil), .I_LOOPBACK_SELECT(lbk),
        .I_TX_FIFO_PRIORITY(fifo), .I_NO_AUTO_RETRANSMIT(no_auto_retransmit),
        .O_INIT_ACKNOWLEDGE(init_acknowledge), .O_SLEEP_ACKNOWLEDGE(sleep_acknowledge),
        .O_SLEEP_REQUEST_CLR(slclr), .O_WAKEUP_IRQ(wirq), .O_IGNORE_ACK_ERR(iack),
        .I_MB_WR_EN(wr), .I_MB_SEL(sel), .I_MB_ID(id), .I_TRANSMIT_REQUEST(strb[1:0]),
        .I_ABORT_REQUEST(strb[3:2]), .I_FLAG_CLEAR(strb[5:4]), .O_MB_STATE(st),
        .O_REQUEST_COMPLETE(request_complete), .O_TRANSMIT_OK(transmit_ok), .O_ARBITRATION_LOST(arbitration_lost),
        .O_TRANSMIT_ERROR(transmit_error), .I_BIT_TICK(tick), .I_BUS_IDLE(idle),
        .I_CORE_TX_BIT(ctx), .I_TX_DONE(ends[0]), .I_TX_ARB_LOST(ends[1]),
        .I_TX_ERROR(ends[2]), .O_CORE_RX_BIT(rxc), .O_TX_START(start), .O_TX_MB(mb),
        .O_TX_ID(tx_id), .I_BUS_RECEIVE_PIN(rx), .O_BUS_TRANSMIT_PIN(txpin));
    task automatic complete_run();
        if (fail_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Ceiling well above the few hundred cycles the scenarios need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            complete_run();
        end
    end
    task automatic check(input string what, input logic [31:0] exp, got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Watch index: 0 wake irq, 1 sleep ack, 2 init ack, 3 start
    task automatic wait_lvl(input int k, input logic lvl);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (seen[k] !== lvl && n < 400);
    endtask
    // Strobe group: 0 request, 1 abort, 2 flag clear
    task automatic pulse(input int k, input logic [1:0] v);
        @(posedge clk) strb <= 6'(v) << (2 * k);
        @(posedge clk) strb <= 6'h0;
    endtask
    task automatic write(input logic b, input logic [ID_W-1:0] v);
        @(posedge clk);
        wr <= 1'b1;
        sel <= b;
        id <= v;
        @(posedge clk) wr <= 1'b0;
    endtask
    // Outcome: 0 done, 1 arbitration lost, 2 error
    task automatic finish_tx(input int k);
        @(posedge clk) ends <= 3'h1 << k;
        @(posedge clk) ends <= 3'h0;
        @(negedge clk);
    endtask
    task automatic t_reset();
        @(negedge clk);
        check("reset_sleep_acknowledge", 1, sleep_acknowledge);
        check("reset_init_acknowledge", 0, init_acknowledge);
        check("reset_txpin", 1, txpin);
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
    endtask
    task automatic t_sleep_wake();
        @(posedge clk) init_rq <= 1'b1;
        repeat (6) @(negedge clk);
        check("init_acknowledge_asleep", 0, init_acknowledge);
        @(posedge clk) init_rq <= 1'b0;
        @(posedge clk) wake <= 1'b1;
        @(posedge clk) wake <= 1'b0;
        wait_lvl(0, 1'b1);
        check("wake_irq", 1, wirq);
        check("sleep_clr", 1, slclr);
        @(posedge clk) sleep_rq <= 1'b0;
        wait_lvl(1, 1'b0);
        check("sleep_acknowledge_low", 0, sleep_acknowledge);
        check("sync_long", 1, n >= 40);
    endtask
    task automatic t_init();
        @(posedge clk) init_rq <= 1'b1;
        wait_lvl(2, 1'b1);
        check("init_acknowledge_fast", 1, n <= 3);
        @(negedge clk);
        check("init_txpin", 1, txpin);
        @(posedge clk) init_rq <= 1'b0;
        wait_lvl(2, 1'b0);
        check("init_acknowledge_low", 0, init_acknowledge);
    endtask
    // Options only ever change in initialization
    task automatic t_test(input logic s, input logic l);
        @(posedge clk) init_rq <= 1'b1;
        wait_lvl(2, 1'b1);
        @(posedge clk) sil <= s;
        lbk <= l;
        @(posedge clk) init_rq <= 1'b0;
        // Room for eleven idle bit times, then a late option change
        repeat (60) @(posedge clk);
        ctx <= 1'b0;
        sil <= !s;
        repeat (2) @(negedge clk);
        check("test_pin", s, txpin);
        check("test_core_rx", 0, rxc);
        check("ack_ignore", l, iack);
        @(posedge clk) ctx <= 1'b1;
        wake <= 1'b1;
        @(posedge clk) wake <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check("pin_ignored", l, rxc);
    endtask
    // First and second winner of two queued boxes; a late write must not land
    task automatic t_pair(input logic fp, input logic [ID_W-1:0] i0, i1,
        input logic [1:0] req, input logic win);
        @(posedge clk) fifo <= fp;
        busy <= 1'b1;
        pulse(2, 2'h3);
        write(1'b0, i0);
        write(1'b1, i1);
        pulse(0, req);
        if (req != 2'h3) pulse(0, ~req);
        write(!win, ID_RESET);
        @(posedge clk) busy <= 1'b0;
        wait_lvl(3, 1'b1);
        check("first_mb", win, mb);
        check("first_id", win ? i1 : i0, tx_id);
        finish_tx(0);
        check("first_empty", 0, win ? st[3:2] : st[1:0]);
        check("first_ok", 1, win ? request_complete[1] & transmit_ok[1] : request_complete[0] & transmit_ok[0]);
        wait_lvl(3, 1'b1);
        check("second_id", win ? i0 : i1, tx_id);
        finish_tx(0);
    endtask
    task automatic t_single(input logic use_err);
        @(posedge clk) no_auto_retransmit <= 1'b1;
        pulse(2, 2'h1);
        write(1'b0, 29'h0000004);
        pulse(0, 2'h1);
        wait_lvl(3, 1'b1);
        finish_tx(use_err ? 2 : 1);
        check("single_state", 0, st[1:0]);
        check("single_flags", {use_err, !use_err, 2'h2}, {transmit_error[0], arbitration_lost[0], request_complete[0], transmit_ok[0]});
    endtask
    task automatic t_abort();
        @(posedge clk) busy <= 1'b1;
        pulse(2, 2'h2);
        write(1'b1, 29'h0000007);
        pulse(0, 2'h2);
        pulse(1, 2'h2);
        @(negedge clk);
        check("abort_state", 0, st[3:2]);
        check("abort_flags", 2'h2, {request_complete[1], transmit_ok[1]});
        @(posedge clk) busy <= 1'b0;
    endtask
    initial begin
        t_reset();
        t_sleep_wake();
        t_init();
        t_pair(1'b0, 29'h0000005, 29'h0000003, 2'h3, 1'b1);
        t_pair(1'b0, 29'h0000009, 29'h0000009, 2'h3, 1'b0);
        t_pair(1'b1, 29'h0000001, 29'h0000002, 2'h2, 1'b1);
        t_single(1'b0);
        t_single(1'b1);
        t_abort();
        t_test(1'b0, 1'b1);
        t_test(1'b1, 1'b0);
        t_test(1'b1, 1'b1);
        complete_run();
    end
endmodule
`default_nettype wire
